// ===== src/mmp_map.svh
// register offsets, field positions, reset values and address ranges
`ifndef MMP_MAP_SVH
`define MMP_MAP_SVH
`define MMP_PAGE_SEL_OFS 16'h001E
`define MMP_MODE_CTL_OFS 16'h001D
`define MMP_PAGE_SEL_RST 4'h0
`define MMP_VPTR_RST 9'h1FF
`define MMP_VPTR_MSB 15
`define MMP_VPTR_LSB 7
`define MMP_BOOT_BIT 6
`define MMP_RAM_OVERLAY_BIT_BIT 5
`define MMP_ADDRESS_VISIBILITY_BIT_BIT 4
`define MMP_DATA_ROM_ENABLE_BIT 3
`define MMP_CLKOFF_BIT 2
`define MMP_SATURATE_ON_MULTIPLY_BIT 1
`define MMP_SST_BIT 0
`define MMP_RAM_LO 16'h0080
`define MMP_RAM_HI 16'h3FFF
`define MMP_RAM_BLK_WORDS 8192
`define MMP_ROM_LO 16'hF000
`define MMP_BOOT_LO 16'hF800
`define MMP_BOOT_HI 16'hFBFF
`define MMP_MULAW_LO 16'hFC00
`define MMP_ALAW_LO 16'hFD00
`define MMP_SINE_LO 16'hFE00
`define MMP_TEST_LO 16'hFF00
`define MMP_TEST_HI 16'hFF7F
`define MMP_VEC_LO 16'hFF80
`define MMP_RESET_VEC 16'hFF80
`define MMP_VEC_WORDS 4
`define MMP_SYNC_STAGES 3
`endif

// ===== src/mmp_pkg.sv
// types for the memory map and program paging block
package mmp_pkg;
   typedef enum logic [2:0] {
      REG_RES, REG_BOOT, REG_MULAW, REG_ALAW, REG_SINE, REG_TEST, REG_VEC
   } mmp_rom_region_t;
   typedef enum logic [2:0] {
      OP_NONE, OP_FAR_IMM, OP_FAR_ACC, OP_FAR_RET, OP_TABLE
   } mmp_far_op_t;
   typedef struct packed {
      logic [8:0] vectorPagePointer;
      logic bootModeSelect;
      logic ramOverlayBit;
      logic addressVisibilityBit;
      logic dataRomEnable;
      logic clockOff;
      logic saturateOnMultiply;
      logic saturateOnStore;
   } mmp_mode_t;
   typedef struct packed {
      logic ramHit;
      logic ramBlock;
      logic romHit;
      logic extHit;
   } mmp_sel_t;
endpackage : mmp_pkg

// ===== src/mmp_memory_map.sv
// address decoder, mode and page registers, dual-access ram and vectors
//
// Operation
// - ram is two 8K-word blocks, each up to three reads plus one write per cycle
// - ram answers data 0080h-3FFFh and program space when overlay is set
// - boot select sampled low at reset starts fetch at rom FF80h
// - rom regions: reserved, bootloader, companding, sine, reserved, vectors
// - rom words FF00h-FF7Fh kept for factory test; code must not use them
// - reset, interrupt or trap loads the pc with its vector address
// - each vector occupies four program words
// - vectors sit at the 128-word page named by the vector page pointer
// - reset loads the pointer with ones, so reset vector is always FF80h
// - mode register holds pointer 15:7 and seven mode bits 6:0
// - program address is twenty bits wide
// - page register at data 001Eh selects the page, cleared by reset
// - far branch, call and return load the page from a 20-bit target
// - table read and write form a 20-bit address from the accumulator
// - other instructions and interrupts keep the page unchanged
// - program memory decodes as 16 pages of 64K words
// - with overlay set ram answers 0080h-3FFFh of every page
`timescale 1ns/10ps
`include "mmp_map.svh"
module mmp_memory_map (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic bootModePin,
   input wire logic [15:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [15:0] regRdData,
   input wire logic [15:0] progAddr,
   input wire logic progRead,
   input wire logic progWrite,
   input wire logic [15:0] progWrData,
   output logic [15:0] progRdData,
   input wire logic [15:0] dataAddrA,
   input wire logic dataReadA,
   output logic [15:0] dataRdDataA,
   input wire logic [15:0] dataAddrB,
   input wire logic dataWriteB,
   input wire logic dataReadB,
   input wire logic [15:0] dataWrDataB,
   output logic [15:0] dataRdDataB,
   input wire mmp_pkg::mmp_far_op_t farOp,
   input wire logic [19:0] farTarget,
   input wire logic [19:0] accAddr,
   input wire logic vectorTake,
   input wire logic [4:0] vectorNum,
   input wire logic resetFetch,
   output logic [15:0] vectorPc,
   output logic [19:0] extProgAddr,
   output logic extProgSel,
   output mmp_pkg::mmp_sel_t progSel,
   output mmp_pkg::mmp_rom_region_t romRegion,
   output logic [15:0] romAddr,
   output logic romRead,
   output logic [3:0] pageNow,
   output mmp_pkg::mmp_mode_t modeNow
);
   import mmp_pkg::*;

   logic [3:0] page_q;
   mmp_mode_t mode_q;
   logic [2:0] bootSync_q;
   logic bootCaught_q;
   logic [15:0] ramBlk0 [`MMP_RAM_BLK_WORDS];
   logic [15:0] ramBlk1 [`MMP_RAM_BLK_WORDS];
   logic [3:0] progPage;
   logic [15:0] progLocal;
   mmp_sel_t pSel;
   mmp_sel_t dSelA;
   mmp_sel_t dSelB;
   logic progRamWr;
   logic dataRamWr;
   logic [15:0] regRd_d;

   function automatic mmp_sel_t decodeData(input logic [15:0] a);
      mmp_sel_t s;
      s.ramHit = (a >= `MMP_RAM_LO) && (a <= `MMP_RAM_HI);
      s.ramBlock = a[13];
      s.romHit = 1'b0;
      s.extHit = !s.ramHit;
      return s;
   endfunction : decodeData

   function automatic mmp_sel_t decodeProg(input logic [15:0] a,
      input logic ram_overlay_bit, input logic [3:0] pg, input logic mc);
      mmp_sel_t s;
      s.ramHit = ram_overlay_bit && (a >= `MMP_RAM_LO) && (a <= `MMP_RAM_HI);
      s.ramBlock = a[13];
      s.romHit = !mc && (pg == 4'h0) && (a >= `MMP_ROM_LO);
      s.extHit = !s.ramHit && !s.romHit;
      return s;
   endfunction : decodeProg

   function automatic mmp_rom_region_t romOf(input logic [15:0] a);
      mmp_rom_region_t r;
      r = REG_RES;
      if (a >= `MMP_VEC_LO) r = REG_VEC;
      else if (a >= `MMP_TEST_LO) r = REG_TEST;
      else if (a >= `MMP_SINE_LO) r = REG_SINE;
      else if (a >= `MMP_ALAW_LO) r = REG_ALAW;
      else if (a >= `MMP_MULAW_LO) r = REG_MULAW;
      else if (a >= `MMP_BOOT_LO) r = REG_BOOT;
      return r;
   endfunction : romOf

   // boot pin synchroniser: no reset, so it holds the pin level at release;
   // the change is counted when stages two and three agree
   always_ff @(posedge clk) begin
      bootSync_q <= {bootSync_q[1:0], bootModePin};
   end

   // boot mode caught in the first cycle after reset release
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bootCaught_q <= 1'b0;
      end else begin
         bootCaught_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q.vectorPagePointer <= `MMP_VPTR_RST;
         mode_q.bootModeSelect <= 1'b1;
         mode_q.ramOverlayBit <= 1'b0;
         mode_q.addressVisibilityBit <= 1'b0;
         mode_q.dataRomEnable <= 1'b0;
         mode_q.clockOff <= 1'b0;
         mode_q.saturateOnMultiply <= 1'b0;
         mode_q.saturateOnStore <= 1'b0;
      end else begin
         if (!bootCaught_q && (bootSync_q[1] == bootSync_q[2])) begin
            mode_q.bootModeSelect <= bootSync_q[2];
         end
         if (regWrite && regAddr == `MMP_MODE_CTL_OFS) begin
            mode_q.vectorPagePointer <=
               regWrData[`MMP_VPTR_MSB:`MMP_VPTR_LSB];
            mode_q.bootModeSelect <= regWrData[`MMP_BOOT_BIT];
            mode_q.ramOverlayBit <= regWrData[`MMP_RAM_OVERLAY_BIT_BIT];
            mode_q.saturateOnMultiply <= regWrData[`MMP_SATURATE_ON_MULTIPLY_BIT];
            mode_q.saturateOnStore <= regWrData[`MMP_SST_BIT];
         end
      end
   end

   // page changes only on far transfers and software writes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         page_q <= `MMP_PAGE_SEL_RST;
      end else begin
         case (farOp)
            OP_FAR_IMM, OP_FAR_ACC, OP_FAR_RET: begin
               page_q <= farTarget[19:16];
            end
            OP_NONE, OP_TABLE: begin
               if (regWrite && regAddr == `MMP_PAGE_SEL_OFS) begin
                  page_q <= regWrData[3:0];
               end
            end
            default: begin
               page_q <= page_q;
            end
         endcase
      end
   end

   always_comb begin
      if (farOp == OP_TABLE) begin
         progPage = accAddr[19:16];
         progLocal = accAddr[15:0];
      end else begin
         progPage = page_q;
         progLocal = progAddr;
      end
   end

   assign pSel = decodeProg(progLocal, mode_q.ramOverlayBit, progPage,
      mode_q.bootModeSelect);
   assign dSelA = decodeData(dataAddrA);
   assign dSelB = decodeData(dataAddrB);
   assign progRamWr = progWrite && pSel.ramHit;
   assign dataRamWr = dataWriteB && dSelB.ramHit;

   // each block: port A read, port B read or write, program read or write
   always_ff @(posedge clk) begin
      if (dataRamWr && !dSelB.ramBlock) begin
         ramBlk0[dataAddrB[12:0]] <= dataWrDataB;
      end else if (progRamWr && !pSel.ramBlock) begin
         ramBlk0[progLocal[12:0]] <= progWrData;
      end
   end

   always_ff @(posedge clk) begin
      if (dataRamWr && dSelB.ramBlock) begin
         ramBlk1[dataAddrB[12:0]] <= dataWrDataB;
      end else if (progRamWr && pSel.ramBlock) begin
         ramBlk1[progLocal[12:0]] <= progWrData;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dataRdDataA <= 16'h0000;
         dataRdDataB <= 16'h0000;
         progRdData <= 16'h0000;
      end else begin
         if (dataReadA && dSelA.ramHit) begin
            dataRdDataA <= dSelA.ramBlock ? ramBlk1[dataAddrA[12:0]]
               : ramBlk0[dataAddrA[12:0]];
         end
         if (dataReadB && dSelB.ramHit) begin
            dataRdDataB <= dSelB.ramBlock ? ramBlk1[dataAddrB[12:0]]
               : ramBlk0[dataAddrB[12:0]];
         end
         if (progRead && pSel.ramHit) begin
            progRdData <= pSel.ramBlock ? ramBlk1[progLocal[12:0]]
               : ramBlk0[progLocal[12:0]];
         end
      end
   end

   always_comb begin
      regRd_d = 16'h0000;
      if (regAddr == `MMP_PAGE_SEL_OFS) begin
         regRd_d = {12'h000, page_q};
      end else if (regAddr == `MMP_MODE_CTL_OFS) begin
         regRd_d = mode_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdData <= 16'h0000;
      end else if (regRead) begin
         regRdData <= regRd_d;
      end else begin
         regRdData <= 16'h0000;
      end
   end

   // vector address: reset fixed at FF80h, others via pointer, 4 words each
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vectorPc <= `MMP_RESET_VEC;
      end else if (resetFetch) begin
         vectorPc <= `MMP_RESET_VEC;
      end else if (vectorTake) begin
         vectorPc <= {mode_q.vectorPagePointer, vectorNum, 2'b00};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         extProgAddr <= 20'h00000;
         extProgSel <= 1'b0;
         romAddr <= 16'h0000;
         romRead <= 1'b0;
         romRegion <= REG_RES;
         progSel <= '0;
      end else begin
         extProgAddr <= {progPage, progLocal};
         extProgSel <= (progRead || progWrite) && pSel.extHit;
         romAddr <= progLocal;
         romRead <= progRead && pSel.romHit;
         romRegion <= romOf(progLocal);
         progSel <= pSel;
      end
   end

   assign pageNow = page_q;
   assign modeNow = mode_q;

   reset_vec_a: assert property (@(posedge clk) disable iff (!rst_n)
      resetFetch |=> vectorPc == `MMP_RESET_VEC)
      else $error("reset vector not at FF80h");
   vec_spacing_a: assert property (@(posedge clk) disable iff (!rst_n)
      vectorTake && !resetFetch |=> vectorPc[1:0] == 2'b00 &&
      vectorPc[15:7] == $past(mode_q.vectorPagePointer))
      else $error("vector address wrong");
   page_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      (farOp == OP_NONE || farOp == OP_TABLE) &&
      !(regWrite && regAddr == `MMP_PAGE_SEL_OFS) |=> $stable(page_q))
      else $error("page changed unexpectedly");
   far_page_a: assert property (@(posedge clk) disable iff (!rst_n)
      farOp == OP_FAR_IMM |=> page_q == $past(farTarget[19:16]))
      else $error("far transfer page not loaded");
   table_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
      farOp == OP_TABLE |=> extProgAddr == $past(accAddr))
      else $error("table address not 20 bits");
   ram_overlay_bit_ram_a: assert property (@(posedge clk) disable iff (!rst_n)
      mode_q.ramOverlayBit && progLocal == `MMP_RAM_LO |=>
      progSel.ramHit && !extProgSel)
      else $error("overlay ram not decoded");
   no_ram_overlay_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
      !mode_q.ramOverlayBit && progLocal < 16'h4000 && progRead |=>
      extProgSel)
      else $error("low program space not external");
   data_ram_a: assert property (@(posedge clk) disable iff (!rst_n)
      dataAddrA >= `MMP_RAM_LO && dataAddrA <= `MMP_RAM_HI |->
      dSelA.ramHit)
      else $error("data ram range missed");
   page_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      regRead && regAddr == `MMP_PAGE_SEL_OFS |=>
      regRdData[3:0] == $past(page_q))
      else $error("page register readback wrong");

   far_jump_c: cover property (@(posedge clk) disable iff (!rst_n)
      farOp == OP_FAR_ACC ##1 page_q != 4'h0);
   vec_move_c: cover property (@(posedge clk) disable iff (!rst_n)
      vectorTake && mode_q.vectorPagePointer != `MMP_VPTR_RST);
   ram_overlay_bit_fetch_c: cover property (@(posedge clk) disable iff (!rst_n)
      progRead && pSel.ramHit && page_q != 4'h0);
   rom_boot_c: cover property (@(posedge clk) disable iff (!rst_n)
      romRead && romRegion == REG_BOOT);
endmodule : mmp_memory_map

// ===== sim/mmp_core_model.sv
// core bus model issuing program and data memory requests
`timescale 1ns/10ps
module mmp_core_model (
   input wire logic clk,
   output logic [15:0] progAddr,
   output logic progRead,
   output logic progWrite,
   output logic [15:0] progWrData,
   output logic [15:0] dataAddrA,
   output logic dataReadA,
   output logic [15:0] dataAddrB,
   output logic dataWriteB,
   output logic dataReadB,
   output logic [15:0] dataWrDataB
);
   initial begin
      {progAddr, progRead, progWrite, progWrData} = '0;
      {dataAddrA, dataReadA, dataAddrB, dataWriteB, dataReadB} = '0;
      dataWrDataB = '0;
   end
   // released address and data B lines show inverted values; progWrData keeps its last value
   task automatic prog(logic [15:0] a, logic wr);
      @(posedge clk);
      progAddr <= a;
      progRead <= !wr;
      progWrite <= wr;
      progWrData <= ~a;
      @(posedge clk);
      {progRead, progWrite} <= 2'b00;
      progAddr <= ~a;
   endtask : prog
   task automatic data(logic [15:0] a, logic [15:0] d, logic wr);
      @(posedge clk);
      {dataAddrA, dataAddrB, dataWrDataB} <= {a, a, d};
      {dataReadA, dataReadB, dataWriteB} <= {!wr, !wr, wr};
      @(posedge clk);
      {dataReadA, dataReadB, dataWriteB} <= 3'b000;
      {dataAddrA, dataAddrB, dataWrDataB} <= {~a, ~a, ~d};
   endtask : data
endmodule : mmp_core_model

// ===== sim/tb.sv
// testbench for the memory map and program paging block
`timescale 1ns/10ps
`include "mmp_map.svh"
module tb;
   import mmp_pkg::*;
   logic clk, rst_n, bootModePin, regWrite, regRead, vectorTake, resetFetch;
   logic [15:0] regAddr, regWrData, regRdData, progAddr, progWrData;
   logic progRead, progWrite, dataReadA, dataWriteB, dataReadB, extProgSel;
   logic [15:0] progRdData, dataAddrA, dataRdDataA, dataAddrB, vectorPc;
   logic [15:0] dataWrDataB, dataRdDataB, ra, rd, m;
   logic [19:0] farTarget, accAddr, extProgAddr, t;
   logic [4:0] vectorNum, vn;
   logic [3:0] pageNow, pg;
   logic romRead;
   logic [15:0] romAddr;
   logic [31:0] seed;
   int fail_count, checks_done;
   mmp_far_op_t farOp;
   mmp_sel_t progSel;
   mmp_rom_region_t romRegion;
   mmp_mode_t modeNow;
   logic [15:0] ramC [4] = '{16'h0080, 16'h1FFF, 16'h2000, 16'h3FFF};
   mmp_far_op_t ops [3] = '{OP_FAR_IMM, OP_FAR_ACC, OP_FAR_RET};
   // region probes skip the factory-test words
   logic [15:0] romA [6] = '{16'hF100, 16'hF900, 16'hFC10, 16'hFD10,
      16'hFE10, 16'hFFA0};
   mmp_rom_region_t romE [6] = '{REG_RES, REG_BOOT, REG_MULAW, REG_ALAW,
      REG_SINE, REG_VEC};
   mmp_memory_map mmp_memory_map_inst (.clk, .rst_n, .bootModePin, .regAddr,
      .regWrData, .regWrite, .regRead, .regRdData, .progAddr, .progRead,
      .progWrite, .progWrData, .progRdData, .dataAddrA, .dataReadA,
      .dataRdDataA, .dataAddrB, .dataWriteB, .dataReadB, .dataWrDataB,
      .dataRdDataB, .farOp, .farTarget, .accAddr, .vectorTake, .vectorNum,
      .resetFetch, .vectorPc, .extProgAddr, .extProgSel, .progSel,
      .romRegion, .romAddr, .romRead, .pageNow, .modeNow);
   mmp_core_model mmp_core_model_inst (.clk, .progAddr, .progRead,
      .progWrite, .progWrData, .dataAddrA, .dataReadA, .dataAddrB,
      .dataWriteB, .dataReadB, .dataWrDataB);
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   function automatic logic [15:0] vecExp(logic [8:0] p, logic [4:0] n);
      return {p, n, 2'b00};
   endfunction : vecExp
   task automatic chk(string n, logic [19:0] e, logic [19:0] g);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic regWr(logic [15:0] a, logic [15:0] d);
      @(posedge clk);
      {regAddr, regWrData, regWrite} <= {a, d, 1'b1};
      @(posedge clk);
      regWrite <= 1'b0;
   endtask : regWr
   task automatic regRd(logic [15:0] a, logic [15:0] e);
      @(posedge clk);
      {regAddr, regRead} <= {a, 1'b1};
      @(posedge clk);
      regRead <= 1'b0;
      #1 chk("regRdData", {4'h0, e}, {4'h0, regRdData});
   endtask : regRd
   task automatic pulse(mmp_far_op_t op, logic vt, logic rf);
      @(posedge clk);
      {farOp, vectorTake, resetFetch} <= {op, vt, rf};
      @(posedge clk);
      {farOp, vectorTake, resetFetch} <= {OP_NONE, 2'b00};
      @(posedge clk);
      #1;
   endtask : pulse
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #900000;
      fail_count++;
      final_report();
   end
   initial begin
      {rst_n, bootModePin, regWrite, regRead, vectorTake, resetFetch} = '0;
      {regAddr, regWrData, farTarget, accAddr, vectorNum} = '0;
      farOp = OP_NONE;
      fail_count = 0;
      checks_done = 0;
      seed = 32'hD0CC3BA8;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      regRd(`MMP_PAGE_SEL_OFS, 16'h0000);
      regRd(`MMP_MODE_CTL_OFS, 16'hFF80);
      regRd(16'h0055, 16'h0000);
      pulse(OP_NONE, 1'b0, 1'b1);
      chk("vectorPc", 20'h0FF80, {4'h0, vectorPc});
      for (int i = 0; i < 8; i++) begin
         rd = 16'(xs());
         ra = (i < 4) ? ramC[i] : 16'h0080 + 16'(xs() % 32'h3F80);
         mmp_core_model_inst.data(ra, rd, 1'b1);
         mmp_core_model_inst.data(ra, 16'h0000, 1'b0);
         #1 chk("dataRdDataA", {4'h0, rd}, {4'h0, dataRdDataA});
         chk("dataRdDataB", {4'h0, rd}, {4'h0, dataRdDataB});
      end
      regWr(`MMP_PAGE_SEL_OFS, 16'h0005);
      regWr(`MMP_MODE_CTL_OFS, 16'hFFBC);
      regRd(`MMP_MODE_CTL_OFS, 16'hFFA0);
      chk("modeNow", 20'h0FFA0, {4'h0, 16'(modeNow)});
      mmp_core_model_inst.prog(ra, 1'b0);
      #1 chk("progRdData", {4'h0, rd}, {4'h0, progRdData});
      chk("extProgSel", 20'h0, {19'h0, extProgSel});
      chk("ramHit", 20'h1, {19'h0, progSel.ramHit});
      regWr(`MMP_MODE_CTL_OFS, 16'hFF80);
      mmp_core_model_inst.prog(16'h0100, 1'b0);
      #1 chk("extProgSel", 20'h1, {19'h0, extProgSel});
      chk("extProgAddr", 20'h50100, extProgAddr);
      regRd(`MMP_PAGE_SEL_OFS, 16'h0005);
      for (int i = 0; i < 3; i++) begin
         t = 20'(xs());
         farTarget <= t;
         pulse(ops[i], 1'b0, 1'b0);
         chk("pageNow", {16'h0, t[19:16]}, {16'h0, pageNow});
         mmp_core_model_inst.prog(16'h9000, 1'(i));
         #1 chk("extProgAddr", {t[19:16], 16'h9000}, extProgAddr);
      end
      pg = t[19:16];
      t = {4'(xs()), 2'b10, 14'(xs())};
      accAddr <= t;
      fork
         pulse(OP_TABLE, 1'b0, 1'b0);
         begin
            mmp_core_model_inst.prog(t[15:0], 1'b0);
            #1 chk("extProgAddr", t, extProgAddr);
         end
      join
      chk("pageNow", {16'h0, pg}, {16'h0, pageNow});
      for (int i = 0; i < 4; i++) begin
         m = 16'(xs()) & 16'hFF80;
         vn = 5'(xs());
         regWr(`MMP_MODE_CTL_OFS, m);
         vectorNum <= vn;
         pulse(OP_NONE, 1'b1, 1'b0);
         chk("vectorPc", {4'h0, vecExp(m[15:7], vn)}, {4'h0, vectorPc});
         chk("pageNow", {16'h0, pg}, {16'h0, pageNow});
         pulse(OP_NONE, 1'b1, 1'b1);
         chk("vectorPc", 20'h0FF80, {4'h0, vectorPc});
      end
      regWr(`MMP_PAGE_SEL_OFS, 16'h0000);
      regWr(`MMP_MODE_CTL_OFS, 16'hFF80);
      for (int i = 0; i < 6; i++) begin
         mmp_core_model_inst.prog(romA[i], 1'b0);
         #1 chk("romRegion", 20'(romE[i]), 20'(romRegion));
         chk("romRead", 20'h1, {19'h0, romRead});
         chk("romAddr", {4'h0, romA[i]}, {4'h0, romAddr});
      end
      final_report();
   end
endmodule : tb
